// >>> hw/kklbl_top.v
// Keyboard key-code encoder and LED line and label display interpreter.
`include "kklbl_map.vh"
`default_nettype none

module kklbl_top #(
	// Arbitrary version characters sent in the identify reply.
	parameter [23:0] VERSION = 24'h313030
) (
	input wire REF_CLK_I,
	input wire RESETN_I,
	input wire KEY_VALID_I,
	input wire [4:0] KEY_CODE_I,
	input wire KEY_SHIFT_I,
	input wire KEY_CTRL_I,
	output wire KEY_READY_O,
	output wire TX_VALID_O,
	output reg [7:0] TX_DATA_O,
	input wire TX_READY_I,
	input wire RX_VALID_I,
	input wire [7:0] RX_DATA_I,
	output wire BELL_O,
	output wire LINE_MODE_O,
	output wire [6:0] LINE_LEN_O,
	input wire [6:0] DISP_ADDR_I,
	output reg [7:0] DISP_CHAR_O,
	input wire [3:0] LBL_SEL_I,
	input wire [2:0] LBL_POS_I,
	output reg [7:0] LBL_CHAR_O,
	output wire [11:0] LBL_BLINK_O
);

	// ------------------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------------------
	// Key number 0-9 digits, 10 period, 11 comma, 12 minus, 13 ENTER,
	// 14-23 device control keys n o p q r s w x y z. Bit 8 flags a known key.
	function [8:0] key_encode;
		input [4:0] key;
		input shift;
		input ctrl;
		reg [7:0] base;
		begin
			base = 8'h00;
			key_encode = 9'h000;
			if (key <= `KKLBL_KEY_DIGIT_LAST) begin
				if (!shift) begin
					key_encode = {1'b1, `KKLBL_DIGIT_BASE + {3'h0, key}};
				end else begin
					case (key)
						5'h00: key_encode = 9'h129;
						5'h01: key_encode = 9'h121;
						5'h02: key_encode = 9'h140;
						5'h03: key_encode = 9'h123;
						5'h04: key_encode = 9'h124;
						5'h05: key_encode = 9'h125;
						5'h06: key_encode = 9'h15E;
						5'h07: key_encode = 9'h126;
						5'h08: key_encode = 9'h12A;
						default: key_encode = 9'h128;
					endcase
				end
			end else if (key == `KKLBL_KEY_PERIOD) begin
				key_encode = shift ? 9'h13E : 9'h12E;
			end else if (key == `KKLBL_KEY_COMMA) begin
				key_encode = shift ? 9'h13C : 9'h12C;
			end else if (key == `KKLBL_KEY_MINUS) begin
				key_encode = shift ? 9'h15F : 9'h12D;
			end else if (key == `KKLBL_KEY_ENTER) begin
				key_encode = {1'b1, `KKLBL_CR};
			end else if (key <= `KKLBL_KEY_DEV_LAST) begin
				case (key)
					5'h0E: base = 8'h6E;
					5'h0F: base = 8'h6F;
					5'h10: base = 8'h70;
					5'h11: base = 8'h71;
					5'h12: base = 8'h72;
					5'h13: base = 8'h73;
					5'h14: base = 8'h77;
					5'h15: base = 8'h78;
					5'h16: base = 8'h79;
					default: base = 8'h7A;
				endcase
				// Shifted cursor keys yield the scroll codes through the same path.
				if (ctrl) begin
					key_encode = {1'b1, base & `KKLBL_CTRL_MASK};
				end else if (shift) begin
					key_encode = {1'b1, base & ~`KKLBL_CASE_BIT};
				end else begin
					key_encode = {1'b1, base};
				end
			end
		end
	endfunction

	// Bit 8 flags a displayable character; lowercase is folded to uppercase.
	function [8:0] disp_char;
		input [7:0] c;
		begin
			if (c >= `KKLBL_SPACE && c <= `KKLBL_PRINT_LAST) begin
				disp_char = {1'b1, c};
			end else if (c >= `KKLBL_LOWER_FIRST && c <= `KKLBL_LOWER_LAST) begin
				disp_char = {1'b1, c & ~`KKLBL_CASE_BIT};
			end else begin
				disp_char = 9'h000;
			end
		end
	endfunction

	// Spaces left of a centred label; odd slack puts the extra space on the right.
	function [3:0] centre_pad;
		input [3:0] n;
		begin
			centre_pad = (`KKLBL_LABEL_SLOTS - n) >> 1;
		end
	endfunction

	// ------------------------------------------------------------------------
	// Receive parser states
	// ------------------------------------------------------------------------
	localparam [2:0] ST_TEXT = 3'b001;
	localparam [2:0] ST_PARAM = 3'b010;
	localparam [2:0] ST_LABEL = 3'b100;

	reg [2:0] state_ff;
	reg [7:0] line_ff [0:`KKLBL_LINE_CHARS-1];
	reg [7:0] lbl_ff [0:`KKLBL_LABELS*`KKLBL_LABEL_CHARS-1];
	reg [7:0] tmp_ff [0:`KKLBL_LABEL_CHARS-1];
	reg [6:0] len_ff;
	reg done_ff;
	reg mode_line_ff;
	reg bell_ff;
	reg [7:0] param_ff;
	reg [3:0] cnt_ff;
	reg [11:0] blink_ff;
	reg reply_pend_ff;
	reg [7:0] tx_buf_ff [1:`KKLBL_REPLY_LEN-1];
	reg [2:0] tx_len_ff;
	reg [2:0] tx_idx_ff;
	reg tx_busy_ff;
	reg key_ready_ff;

	wire [8:0] rx_disp = disp_char(RX_DATA_I);
	wire [8:0] key_word = key_encode(KEY_CODE_I, KEY_SHIFT_I, KEY_CTRL_I);
	// Control-E and control-G act only between commands; inside a label they are ignored.
	wire rx_enq = RX_VALID_I && state_ff == ST_TEXT && RX_DATA_I == `KKLBL_ENQ;
	wire rx_bel = RX_VALID_I && state_ff == ST_TEXT && RX_DATA_I == `KKLBL_BEL;
	wire key_take = KEY_VALID_I && key_ready_ff && key_word[8];
	wire tx_last = tx_idx_ff == tx_len_ff - 3'h1;
	wire [3:0] loc = param_ff[3:0];
	wire [3:0] pad = centre_pad(cnt_ff);
	reg nxt_busy;
	reg nxt_pend;
	integer i;
	integer j;

	assign KEY_READY_O = key_ready_ff;
	assign TX_VALID_O = tx_busy_ff;
	assign BELL_O = bell_ff;
	assign LINE_MODE_O = mode_line_ff;
	assign LINE_LEN_O = len_ff;
	assign LBL_BLINK_O = blink_ff;

	// ------------------------------------------------------------------------
	// Receive interpreter
	// ------------------------------------------------------------------------
	// The whole line and label store is flip-flops so that a clear or a shift
	// finishes in one cycle; the receiver never has to stall the host.
	always @(posedge REF_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			state_ff <= ST_TEXT;
			len_ff <= 7'h00;
			done_ff <= 1'b0;
			mode_line_ff <= 1'b1;
			param_ff <= 8'h00;
			cnt_ff <= 4'h0;
			blink_ff <= 12'h000;
			for (i = 0; i < `KKLBL_LINE_CHARS; i = i + 1) begin
				line_ff[i] <= `KKLBL_SPACE;
			end
			for (i = 0; i < `KKLBL_LABELS * `KKLBL_LABEL_CHARS; i = i + 1) begin
				lbl_ff[i] <= `KKLBL_SPACE;
			end
			for (i = 0; i < `KKLBL_LABEL_CHARS; i = i + 1) begin
				tmp_ff[i] <= `KKLBL_SPACE;
			end
		end else begin
			if (RX_VALID_I) begin
				case (state_ff)
					ST_TEXT: begin
						if (RX_DATA_I == `KKLBL_PREFIX) begin
							state_ff <= ST_PARAM;
						end else if (RX_DATA_I == `KKLBL_CR) begin
							// The line stays on show until the next valid character arrives.
							done_ff <= 1'b1;
						end else if (RX_DATA_I == `KKLBL_BS && mode_line_ff) begin
							for (i = 0; i < `KKLBL_LINE_CHARS - 1; i = i + 1) begin
								line_ff[i] <= line_ff[i+1];
							end
							line_ff[`KKLBL_LINE_CHARS-1] <= `KKLBL_SPACE;
							if (len_ff != 7'h00) begin
								len_ff <= len_ff - 7'h01;
							end
						end else if (RX_DATA_I == `KKLBL_DEL && mode_line_ff) begin
							if (len_ff != 7'h00) begin
								line_ff[len_ff-7'h01] <= `KKLBL_SPACE;
								len_ff <= len_ff - 7'h01;
							end
						end else if (rx_disp[8]) begin
							mode_line_ff <= 1'b1;
							if (done_ff || !mode_line_ff) begin
								for (i = 1; i < `KKLBL_LINE_CHARS; i = i + 1) begin
									line_ff[i] <= `KKLBL_SPACE;
								end
								line_ff[0] <= rx_disp[7:0];
								len_ff <= 7'h01;
								done_ff <= 1'b0;
							end else if (len_ff < `KKLBL_LINE_CHARS) begin
								line_ff[len_ff] <= rx_disp[7:0];
								len_ff <= len_ff + 7'h01;
							end
							// A full line drops further text until a return, a backspace or a delete.
						end
					end
					ST_PARAM: begin
						param_ff <= RX_DATA_I;
						cnt_ff <= 4'h0;
						state_ff <= ST_LABEL;
					end
					ST_LABEL: begin
						if (RX_DATA_I == `KKLBL_CR) begin
							state_ff <= ST_TEXT;
							mode_line_ff <= 1'b0;
							// Labels beyond the last location are parsed to the return and dropped.
							if (loc <= `KKLBL_LAST_LABEL) begin
								blink_ff[loc] <= param_ff[`KKLBL_BLINK_BIT];
								if (cnt_ff != 4'h0) begin
									for (i = 0; i < `KKLBL_LABEL_CHARS; i = i + 1) begin
										if (param_ff[`KKLBL_JUST_BIT]) begin
											lbl_ff[loc*`KKLBL_LABEL_CHARS+i] <= (i < cnt_ff) ?
												tmp_ff[i] : `KKLBL_SPACE;
										end else begin
											lbl_ff[loc*`KKLBL_LABEL_CHARS+i] <= (i >= pad && i < pad + cnt_ff) ?
												tmp_ff[i-pad] : `KKLBL_SPACE;
										end
									end
								end
							end
						end else if (rx_disp[8] && cnt_ff < `KKLBL_LABEL_CHARS) begin
							tmp_ff[cnt_ff[2:0]] <= rx_disp[7:0];
							cnt_ff <= cnt_ff + 4'h1;
						end
					end
					default: begin
						state_ff <= ST_TEXT;
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------------------
	// Display read ports
	// ------------------------------------------------------------------------
	// Reads are registered so that both display outputs come straight from flip-flops.
	always @(posedge REF_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			DISP_CHAR_O <= `KKLBL_SPACE;
		end else begin
			DISP_CHAR_O <= (DISP_ADDR_I < `KKLBL_LINE_CHARS) ? line_ff[DISP_ADDR_I] : `KKLBL_SPACE;
		end
	end

	always @(posedge REF_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			LBL_CHAR_O <= `KKLBL_SPACE;
		end else begin
			LBL_CHAR_O <= (LBL_SEL_I <= `KKLBL_LAST_LABEL) ? lbl_ff[{LBL_SEL_I, LBL_POS_I}] : `KKLBL_SPACE;
		end
	end

	// ------------------------------------------------------------------------
	// Bell pulse
	// ------------------------------------------------------------------------
	// The bell is a one-cycle pulse; the sounder has to stretch it to be heard.
	always @(posedge REF_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			bell_ff <= 1'b0;
		end else begin
			bell_ff <= rx_bel;
		end
	end

	// ------------------------------------------------------------------------
	// Transmit sequencer
	// ------------------------------------------------------------------------
	// A pending version reply holds off new key codes; a key taken in the same cycle as the control-E goes out first.
	// A byte moves on only at a handshake edge, so a stalled host sees it stand.
	always @* begin
		nxt_busy = tx_busy_ff ? !(TX_READY_I && tx_last) : (reply_pend_ff || key_take);
		nxt_pend = rx_enq || (reply_pend_ff && tx_busy_ff);
	end

	always @(posedge REF_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			reply_pend_ff <= 1'b0;
			tx_busy_ff <= 1'b0;
			tx_len_ff <= 3'h0;
			tx_idx_ff <= 3'h0;
			key_ready_ff <= 1'b0;
			TX_DATA_O <= 8'h00;
			for (j = 1; j < `KKLBL_REPLY_LEN; j = j + 1) begin
				tx_buf_ff[j] <= 8'h00;
			end
		end else begin
			reply_pend_ff <= nxt_pend;
			key_ready_ff <= !nxt_busy && !nxt_pend;
			tx_busy_ff <= nxt_busy;
			if (tx_busy_ff) begin
				if (TX_READY_I && !tx_last) begin
					tx_idx_ff <= tx_idx_ff + 3'h1;
					TX_DATA_O <= tx_buf_ff[tx_idx_ff+3'h1];
				end
			end else if (reply_pend_ff) begin
				// Slot 0 is not stored: a message's first byte goes straight to the output.
				tx_buf_ff[1] <= `KKLBL_CHAR_B;
				tx_buf_ff[2] <= VERSION[23:16];
				tx_buf_ff[3] <= VERSION[15:8];
				tx_buf_ff[4] <= VERSION[7:0];
				tx_buf_ff[5] <= `KKLBL_CHAR_D;
				tx_len_ff <= `KKLBL_REPLY_LEN;
				tx_idx_ff <= 3'h0;
				TX_DATA_O <= `KKLBL_CHAR_K;
			end else if (key_take) begin
				tx_buf_ff[1] <= key_word[7:0];
				tx_len_ff <= `KKLBL_KEY_LEN;
				tx_idx_ff <= 3'h0;
				TX_DATA_O <= `KKLBL_PREFIX;
			end
		end
	end

endmodule

`default_nettype wire

// >>> hw/kklbl_map.vh
// Constants for the keyboard key-code encoder and LED display interpreter.
// Operation
// - Every pad or device control key code goes out behind a 0x16 prefix byte.
// - Pad ENTER always sends 0x0D; CTRL never changes any pad code.
// - Pad digits send 0x30 upward alone, shifted symbols with SHIFT; minus, period, comma alike.
// - Device control keys send lowercase alone, uppercase shifted, control code with CTRL.
// - Shifted cursor-up acts as scroll-up, shifted cursor-down as scroll-down.
// - Display accepts printable characters and space; lowercase is shown as uppercase.
// - Control-E makes the keyboard answer K, B, three version characters, then D.
// - Control-G sounds the bell; unrecognised characters are dropped without effect.
// - Line mode fills left to right, left-justified, up to 96 characters.
// - Backspace shifts the line left, delete drops the last character, line mode only.
// - After a carriage return the next valid character clears the line and starts it.
// - Label command is 0x16, parameter byte, up to eight characters, carriage return.
// - Parameter low nibble picks the label; 0 to 11 sit over F1 to F12.
// - Blink flag set makes the chosen label blink; clear makes it steady.
// - A label command with no characters changes only the blink state.
// - Justify flag set places text left, space-filled; clear centres it.
// - Parameter 0x05 gives a steady centred label at location 5, over F6.
// - Parameter 0x3B gives a blinking left-justified label at location 11, over F12.
`ifndef KKLBL_MAP_VH
`define KKLBL_MAP_VH

// ----------------------------------------------------------------------------
// Character codes
// ----------------------------------------------------------------------------
`define KKLBL_PREFIX 8'h16
`define KKLBL_CR 8'h0D
`define KKLBL_ENQ 8'h05
`define KKLBL_BEL 8'h07
`define KKLBL_BS 8'h08
`define KKLBL_DEL 8'h7F
`define KKLBL_SPACE 8'h20
`define KKLBL_PRINT_LAST 8'h5F
`define KKLBL_LOWER_FIRST 8'h61
`define KKLBL_LOWER_LAST 8'h7A
`define KKLBL_CASE_BIT 8'h20
`define KKLBL_CTRL_MASK 8'h1F
`define KKLBL_DIGIT_BASE 8'h30
`define KKLBL_CHAR_K 8'h4B
`define KKLBL_CHAR_B 8'h42
`define KKLBL_CHAR_D 8'h44

// ----------------------------------------------------------------------------
// Label parameter byte and display sizes
// ----------------------------------------------------------------------------
`define KKLBL_BLINK_BIT 5
`define KKLBL_JUST_BIT 4
`define KKLBL_LAST_LABEL 4'hB
`define KKLBL_LABELS 12
`define KKLBL_LINE_CHARS 96
`define KKLBL_LABEL_CHARS 8
`define KKLBL_LABEL_SLOTS 4'h8

// ----------------------------------------------------------------------------
// Key numbering on the key input
// ----------------------------------------------------------------------------
`define KKLBL_KEY_DIGIT_LAST 5'h09
`define KKLBL_KEY_PERIOD 5'h0A
`define KKLBL_KEY_COMMA 5'h0B
`define KKLBL_KEY_MINUS 5'h0C
`define KKLBL_KEY_ENTER 5'h0D
`define KKLBL_KEY_DEV_LAST 5'h17
`define KKLBL_KEY_CURSOR_UP 5'h16
`define KKLBL_KEY_CURSOR_DOWN 5'h17

// ----------------------------------------------------------------------------
// Transmit sequencing
// ----------------------------------------------------------------------------
`define KKLBL_KEY_LEN 3'h2
`define KKLBL_REPLY_LEN 3'h6

`endif

// >>> tb/kklbl_assertions.sv
// Port checker for the key-code encoder and display interpreter.
`default_nettype none

module kklbl_chk (
	input wire logic REF_CLK_I,
	input wire logic RESETN_I,
	input wire logic KEY_VALID_I,
	input wire logic [4:0] KEY_CODE_I,
	input wire logic KEY_READY_O,
	input wire logic TX_VALID_O,
	input wire logic [7:0] TX_DATA_O,
	input wire logic TX_READY_I,
	input wire logic RX_VALID_I,
	input wire logic [7:0] RX_DATA_I,
	input wire logic BELL_O,
	input wire logic LINE_MODE_O,
	input wire logic [6:0] LINE_LEN_O,
	input wire logic [11:0] LBL_BLINK_O
);
	timeunit 1ns;
	timeprecision 100ps;
	// Where the byte stream stands: 0 between commands, 1 parameter next, 2 label text.
	logic [1:0] rx_pos;
	always @(posedge REF_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			rx_pos <= 2'h0;
		end else if (RX_VALID_I) begin
			case (rx_pos)
				2'h0: rx_pos <= (RX_DATA_I == 8'h16) ? 2'h1 : 2'h0;
				2'h1: rx_pos <= 2'h2;
				default: rx_pos <= (RX_DATA_I == 8'h0D) ? 2'h0 : 2'h2;
			endcase
		end
	end
	default clocking @(posedge REF_CLK_I);
	endclocking
	default disable iff (!RESETN_I);
	// ----------------------------------------
	// Transmit side
	// ----------------------------------------
	AST_PREFIX: assert property (KEY_VALID_I && KEY_READY_O && KEY_CODE_I < 5'h18
		|=> TX_VALID_O && TX_DATA_O == 8'h16)
		else $error("key code not led by prefix");
	AST_HOLD: assert property (TX_VALID_O && !TX_READY_I |=> TX_VALID_O && $stable(TX_DATA_O))
		else $error("byte dropped before handshake");
	AST_REPLY: assert property (RX_VALID_I && RX_DATA_I == 8'h05 && rx_pos == 2'h0 && KEY_READY_O
		&& !KEY_VALID_I |-> ##[1:4] (TX_VALID_O && TX_DATA_O == 8'h4B))
		else $error("no reply to control-E");
	// ----------------------------------------
	// Receive side
	// ----------------------------------------
	AST_BELL: assert property ($rose(BELL_O) |-> $past(RX_VALID_I) && $past(RX_DATA_I) == 8'h07)
		else $error("bell without control-G");
	AST_LEN_MAX: assert property (LINE_LEN_O <= 7'h60)
		else $error("line longer than 96");
	AST_LEN_CAUSE: assert property ($changed(LINE_LEN_O) |-> $past(RX_VALID_I))
		else $error("line length moved without a byte");
	AST_BS_LABEL: assert property (!LINE_MODE_O && RX_VALID_I && RX_DATA_I == 8'h08 |=> $stable(LINE_LEN_O))
		else $error("backspace acted in label mode");
	AST_BLINK: assert property ($changed(LBL_BLINK_O) |-> $past(RX_VALID_I) && $past(RX_DATA_I) == 8'h0D)
		else $error("blink changed before return");
	AST_MODE: assert property ($fell(LINE_MODE_O) |-> $past(RX_VALID_I) && $past(RX_DATA_I) == 8'h0D)
		else $error("label mode entered before return");
endmodule

bind kklbl_top kklbl_chk u_chk (.REF_CLK_I(REF_CLK_I), .RESETN_I(RESETN_I), .KEY_VALID_I(KEY_VALID_I),
	.KEY_CODE_I(KEY_CODE_I), .KEY_READY_O(KEY_READY_O), .TX_VALID_O(TX_VALID_O), .TX_DATA_O(TX_DATA_O),
	.TX_READY_I(TX_READY_I), .RX_VALID_I(RX_VALID_I), .RX_DATA_I(RX_DATA_I), .BELL_O(BELL_O),
	.LINE_MODE_O(LINE_MODE_O), .LINE_LEN_O(LINE_LEN_O), .LBL_BLINK_O(LBL_BLINK_O));

`default_nettype wire

// >>> tb/kklbl_host.sv
// Host model that takes bytes from the keyboard, stalling on request.
`default_nettype none

module kklbl_host (
	input wire logic clk_i,
	input wire logic tx_valid_i,
	input wire logic [7:0] tx_data_i,
	input wire logic stall_i,
	output logic tx_ready_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] got[$];
	initial tx_ready_o = 1'b0;
	// ----------------------------------------
	// Receiver
	// ----------------------------------------
	// Stalling every other cycle proves that the keyboard holds each byte.
	always @(posedge clk_i) begin
		if (tx_valid_i && tx_ready_o)
			got.push_back(tx_data_i);
		tx_ready_o <= #1 stall_i ? !tx_ready_o : 1'b1;
	end
endmodule

`default_nettype wire

// >>> tb/tb_top.sv
// Testbench: key presses, control replies, line and label display.
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin failures++; \
	$display("wrong value at %0t: %h %h", $time, a, e); end end

module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0, rstn = 1'b0, kv = 1'b0, ks = 1'b0, kc = 1'b0, rv = 1'b0, stall = 1'b0;
	logic [4:0] kcode = 5'h00;
	logic [7:0] rd = 8'h00;
	logic [6:0] da = 7'h00;
	logic [3:0] ls = 4'h0;
	logic [2:0] lp = 3'h0;
	wire kr, tv, trdy, bell, lm;
	wire [7:0] td, dc, lc;
	wire [6:0] len;
	wire [11:0] blink;
	int failures = 0, n_checks = 0;
	// Each entry packs key number, SHIFT, CTRL and the expected code.
	logic [14:0] kt [14] = '{15'h0030, 15'h2628, 15'h1535, 15'h1B5E, 15'h2A3E, 15'h2C2C, 15'h325F,
		15'h370D, 15'h4471, 15'h4651, 15'h4511, 15'h5A59, 15'h5E5A, 15'h3B0E};
	logic [7:0] rep [6] = '{8'h4B, 8'h42, 8'h31, 8'h30, 8'h30, 8'h44};
	always #4 clk = ~clk;
	kklbl_top dut (.REF_CLK_I(clk), .RESETN_I(rstn), .KEY_VALID_I(kv), .KEY_CODE_I(kcode), .KEY_SHIFT_I(ks),
		.KEY_CTRL_I(kc), .KEY_READY_O(kr), .TX_VALID_O(tv), .TX_DATA_O(td), .TX_READY_I(trdy), .RX_VALID_I(rv),
		.RX_DATA_I(rd), .BELL_O(bell), .LINE_MODE_O(lm), .LINE_LEN_O(len), .DISP_ADDR_I(da), .DISP_CHAR_O(dc),
		.LBL_SEL_I(ls), .LBL_POS_I(lp), .LBL_CHAR_O(lc), .LBL_BLINK_O(blink));
	kklbl_host host (.clk_i(clk), .tx_valid_i(tv), .tx_data_i(td), .stall_i(stall), .tx_ready_o(trdy));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic results;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic bytes(input int n);
		for (int i = 0; i < 60 && host.got.size() < n; i++)
			cyc(1);
		if (host.got.size() < n) begin
			failures++;
			results();
		end
	endtask
	task automatic press(input logic [14:0] e);
		host.got.delete();
		for (int i = 0; i < 50 && kr !== 1'b1; i++)
			cyc(1);
		if (kr !== 1'b1) begin
			failures++;
			results();
		end
		{kcode, ks, kc} = e[14:8];
		kv = 1'b1;
		cyc(1);
		kv = 1'b0;
		`CHK(kr, 1'b0)
		bytes(2);
		`CHK(host.got[0], 8'h16)
		`CHK(host.got[1], e[7:0])
	endtask
	task automatic sendb(input logic [7:0] b);
		rd = b;
		rv = 1'b1;
		cyc(1);
		rv = 1'b0;
	endtask
	task automatic sends(input string s);
		for (int i = 0; i < s.len(); i++)
			sendb(s[i]);
	endtask
	task automatic label(input logic [7:0] p, input string s);
		sendb(8'h16);
		sendb(p);
		sends(s);
		sendb(8'h0D);
		cyc(1);
	endtask
	task automatic line(input logic [6:0] a, input logic [7:0] e);
		da = a;
		cyc(2);
		`CHK(dc, e)
	endtask
	task automatic lbl(input logic [3:0] s, input logic [2:0] p, input logic [7:0] e);
		ls = s;
		lp = p;
		cyc(2);
		`CHK(lc, e)
	endtask
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		repeat (4) @(posedge clk);
		#1 rstn = 1'b1;
		cyc(2);
		foreach (kt[i]) begin
			stall = i[0];
			press(kt[i]);
		end
		$display("key test done");
		host.got.delete();
		stall = 1'b1;
		sendb(8'h05);
		bytes(6);
		foreach (rep[i])
			`CHK(host.got[i], rep[i])
		sendb(8'h07);
		`CHK(bell, 1'b1)
		sendb(8'h01);
		`CHK(bell, 1'b0)
		`CHK(len, 7'h00)
		$display("reply and bell test done");
		sends("ab");
		cyc(1);
		`CHK(len, 7'h02)
		line(7'h00, 8'h41);
		sendb(8'h7F);
		cyc(1);
		`CHK(len, 7'h01)
		line(7'h01, 8'h20);
		sends("c\010");
		cyc(1);
		line(7'h00, 8'h43);
		sends("\015z");
		cyc(1);
		`CHK(len, 7'h01)
		line(7'h00, 8'h5A);
		line(7'h01, 8'h20);
		sendb(8'h0D);
		for (int i = 0; i < 100; i++)
			sendb(8'(8'h30 + i % 10));
		cyc(1);
		`CHK(len, 7'h60)
		line(7'h5F, 8'h35);
		sendb(8'h0D);
		$display("line test done");
		label(8'h05, "XY");
		`CHK(lm, 1'b0)
		`CHK(blink[5], 1'b0)
		lbl(4'h5, 3'h3, 8'h58);
		lbl(4'h5, 3'h0, 8'h20);
		label(8'h3B, "AB");
		`CHK(blink[11], 1'b1)
		lbl(4'hB, 3'h1, 8'h42);
		lbl(4'hB, 3'h2, 8'h20);
		label(8'h25, "");
		`CHK(blink[5], 1'b1)
		lbl(4'h5, 3'h4, 8'h59);
		sendb(8'h08);
		cyc(1);
		`CHK(len, 7'h60)
		sendb(8'h71);
		cyc(1);
		`CHK(lm, 1'b1)
		`CHK(len, 7'h01)
		line(7'h00, 8'h51);
		line(7'h5F, 8'h20);
		$display("label test done");
		results();
	end
endmodule

`default_nettype wire
